// *** uart_ctl_pkg.sv ***
// Register map, field positions and constants of the serial port
package uart_ctl_pkg;
	localparam logic [15:0] ADDR_MODE = 16'hff70;
	localparam logic [15:0] ADDR_BAUD = 16'hff71;
	localparam logic [15:0] ADDR_ERRS = 16'hff73;
	localparam logic [15:0] ADDR_TXSR = 16'hff72;
	localparam logic [15:0] ADDR_RXBF = 16'hff74;
	localparam logic [7:0] MODE_RESET = 8'h01;
	localparam logic [7:0] BAUD_RESET = 8'h1f;
	localparam logic [7:0] ERRS_RESET = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam int POWER_BIT = 7;
	localparam int TXEN_BIT = 6;
	localparam int RXEN_BIT = 5;
	localparam int PAR_HI = 4;
	localparam int PAR_LO = 3;
	localparam int CHAR_BIT = 2;
	localparam int STOP_BIT = 1;
	localparam int PE_BIT = 2;
	localparam int FE_BIT = 1;
	localparam int OVE_BIT = 0;
	localparam int CSEL_HI = 6;
	localparam int CSEL_LO = 5;
	localparam int DIV_HI = 4;
	localparam int DIV_LO = 0;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam logic [1:0] CSEL_TIMER = 2'h0;
	localparam logic [1:0] CSEL_DIV2 = 2'h1;
	localparam logic [1:0] CSEL_DIV8 = 2'h2;
	localparam logic [1:0] CSEL_DIV32 = 2'h3;
	localparam logic [4:0] PRE_DIV2 = 5'h01;
	localparam logic [4:0] PRE_DIV8 = 5'h07;
	localparam logic [4:0] PRE_DIV32 = 5'h1f;
	localparam logic [3:0] BITS_7 = 4'h7;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] HALF_TICKS = 4'h1;
	localparam logic [1:0] ENA_SYNC_STAGES = 2'h2;
endpackage

// *** baud_if.sv ***
// Baud tick and enable signals shared between the top and the baud generator
`timescale 1ns/100ps
interface baud_if;
	logic base_tick;
	logic bit_tick;
	logic [1:0] clock_sel;
	logic [4:0] divisor;
	logic run;
	modport gen (input clock_sel, input divisor, input run, output base_tick, output bit_tick);
	modport use_side (output clock_sel, output divisor, output run, input base_tick, input bit_tick);
endinterface

// *** baud_gen.sv ***
// Base clock select, 5-bit divider and final halving stage
`timescale 1ns/100ps
module baud_gen
	import uart_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic timer_tick,
	baud_if.gen bif
);
	typedef struct packed {
		logic [4:0] pre;
		logic [4:0] cnt;
		logic half;
		logic base_tick;
		logic bit_tick;
	} bg_state_t;
	bg_state_t st_ff;
	bg_state_t nxt_st;
	logic base_en;
	logic [4:0] pre_max;

	// Prescaler end value from clock select
	always_comb begin
		case (bif.clock_sel)
			CSEL_DIV2: pre_max = PRE_DIV2;
			CSEL_DIV8: pre_max = PRE_DIV8;
			CSEL_DIV32: pre_max = PRE_DIV32;
			default: pre_max = '0;
		endcase
	end

	// Timer option uses the timer tick as base clock
	assign base_en = (bif.clock_sel == CSEL_TIMER) ? timer_tick : (st_ff.pre == pre_max); //RULE20

	// Divide base by k, then halve for the bit rate
	always_comb begin
		nxt_st = st_ff;
		nxt_st.base_tick = 1'b0;
		nxt_st.bit_tick = 1'b0;
		nxt_st.pre = (st_ff.pre == pre_max) ? '0 : st_ff.pre + 5'h01;
		if (!bif.run) begin
			nxt_st.cnt = '0;
			nxt_st.half = 1'b0;
		end else if (base_en) begin
			nxt_st.base_tick = 1'b1;
			if (st_ff.cnt >= bif.divisor - 5'h01) begin //RULE21
				nxt_st.cnt = '0;
				nxt_st.half = ~st_ff.half;
				nxt_st.bit_tick = st_ff.half; //RULE22
			end else begin
				nxt_st.cnt = st_ff.cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) st_ff <= '0;
		else st_ff <= nxt_st;
	end

	assign bif.base_tick = st_ff.base_tick;
	assign bif.bit_tick = st_ff.bit_tick;

	// Bit tick comes once per two divider wraps
	property p_bit_spacing;
		@(posedge clk) disable iff (!rst_n) st_ff.bit_tick |=> !st_ff.bit_tick;
	endproperty
	a_bit_spacing: assert property (p_bit_spacing) else $error("bit tick too close"); //RULE22
	property p_cnt_bound;
		@(posedge clk) disable iff (!rst_n) bif.divisor[4:3] != 2'h0 |-> st_ff.cnt < bif.divisor;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("divider past k"); //RULE21
endmodule

// *** uart_frame.sv ***
// Serial shifter: one state machine per direction, ticked at sixteenth-free bit rate
`timescale 1ns/100ps
module uart_frame
	import uart_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_clr,
	input wire logic rx_clr,
	input wire logic base_tick,
	input wire logic bit_tick,
	input wire logic [1:0] parity_mode,
	input wire logic eight_bits,
	input wire logic two_stops,
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	input wire logic rx_line,
	output logic tx_line,
	output logic tx_busy,
	output logic rx_done,
	output logic [7:0] rx_byte,
	output logic rx_par_err,
	output logic rx_frm_err
);
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_DATA = 2'b01,
		FS_PAR = 2'b10,
		FS_STOP = 2'b11
	} fs_t;
	typedef struct packed {
		fs_t ts;
		logic [7:0] tsh;
		logic [3:0] tcnt;
		logic tpar;
		logic tline;
		logic tstart;
		fs_t rs;
		logic rstart;
		logic [7:0] rsh;
		logic [3:0] rcnt;
		logic rpar;
		logic rdone;
		logic [7:0] rbyte;
		logic rpe;
		logic rfe;
	} fr_state_t;
	fr_state_t st_ff;
	fr_state_t nxt_st;
	logic [3:0] nbits;

	// Parity bit to send or expect for a mode
	function automatic logic par_of(input logic [1:0] m, input logic x);
		case (m)
			PAR_ODD: par_of = ~x;
			PAR_EVEN: par_of = x;
			default: par_of = 1'b0;
		endcase
	endfunction

	assign nbits = eight_bits ? BITS_8 : BITS_7; //RULE7

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdone = 1'b0;
		// Transmit: start, LSB first data, parity, stops
		case (st_ff.ts)
			FS_IDLE: begin
				nxt_st.tline = 1'b1;
				if (tx_load) begin //RULE23
					nxt_st.tsh = eight_bits ? tx_byte : {1'b0, tx_byte[6:0]};
					nxt_st.tpar = par_of(parity_mode, ^(eight_bits ? tx_byte : {1'b0, tx_byte[6:0]}));
					// Start waits for the bit tick, else the free-running divider cuts it short
					nxt_st.tstart = 1'b1;
					nxt_st.tcnt = '0;
					nxt_st.ts = FS_DATA;
				end
			end
			FS_DATA: if (bit_tick) begin
				if (st_ff.tstart) begin
					nxt_st.tstart = 1'b0;
					nxt_st.tline = 1'b0; //RULE25
				end else begin
					nxt_st.tline = st_ff.tsh[0];
					nxt_st.tsh = st_ff.tsh >> 1;
					nxt_st.tcnt = st_ff.tcnt + 4'h1;
					if (st_ff.tcnt == nbits - 4'h1) begin
						nxt_st.ts = (parity_mode == PAR_NONE) ? FS_STOP : FS_PAR; //RULE5
						nxt_st.tcnt = '0;
					end
				end
			end
			FS_PAR: if (bit_tick) begin
				nxt_st.tline = st_ff.tpar; //RULE5
				nxt_st.ts = FS_STOP;
				nxt_st.tcnt = '0;
			end
			default: if (bit_tick) begin
				// First tick raises the stop level, then one or two full bit times
				nxt_st.tline = 1'b1;
				nxt_st.tcnt = st_ff.tcnt + 4'h1;
				if (st_ff.tcnt == {3'h0, two_stops} + 4'h1) nxt_st.ts = FS_IDLE; //RULE8
			end
		endcase
		// Receive: sample on bit ticks, skipping the tick that lies inside the start bit
		case (st_ff.rs)
			FS_IDLE: if (!rx_line) begin //RULE12
				nxt_st.rs = FS_DATA;
				// A tick in the detect cycle already lies inside the start bit
				nxt_st.rstart = !bit_tick;
				nxt_st.rcnt = '0;
				nxt_st.rpar = 1'b0;
			end
			FS_DATA: if (bit_tick) begin
				if (st_ff.rstart) begin
					nxt_st.rstart = 1'b0;
				end else begin
					nxt_st.rsh = {rx_line, st_ff.rsh[7:1]};
					nxt_st.rpar = st_ff.rpar ^ rx_line;
					nxt_st.rcnt = st_ff.rcnt + 4'h1;
					if (st_ff.rcnt == nbits - 4'h1)
						nxt_st.rs = (parity_mode == PAR_NONE) ? FS_STOP : FS_PAR;
				end
			end
			FS_PAR: if (bit_tick) begin
				nxt_st.rpar = (par_of(parity_mode, st_ff.rpar) != rx_line); //RULE17
				nxt_st.rs = FS_STOP;
			end
			default: if (bit_tick) begin
				// Only the first stop is checked
				nxt_st.rs = FS_IDLE; //RULE9
				nxt_st.rdone = 1'b1;
				nxt_st.rfe = ~rx_line; //RULE18
				nxt_st.rpe = (parity_mode == PAR_ODD || parity_mode == PAR_EVEN) && st_ff.rpar; //RULE6
				nxt_st.rbyte = eight_bits ? st_ff.rsh : {1'b0, st_ff.rsh[7:1]}; //RULE24
			end
		endcase
		if (parity_mode == PAR_NONE && st_ff.rs == FS_DATA) nxt_st.rpar = 1'b0;
		if (tx_clr) begin //RULE3
			nxt_st.ts = FS_IDLE;
			nxt_st.tline = 1'b1;
			nxt_st.tstart = 1'b0;
			nxt_st.tsh = BYTE_ONES;
		end
		if (rx_clr) begin //RULE4
			nxt_st.rs = FS_IDLE;
			nxt_st.rdone = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.tline <= 1'b1;
			st_ff.tsh <= BYTE_ONES;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tx_line = st_ff.tline;
	assign tx_busy = st_ff.ts != FS_IDLE;
	assign rx_done = st_ff.rdone;
	assign rx_byte = st_ff.rbyte;
	assign rx_par_err = st_ff.rpe;
	assign rx_frm_err = st_ff.rfe;

	// Load is taken at once; the start bit follows on the next bit tick
	property p_tx_take;
		@(posedge clk) disable iff (!rst_n) (st_ff.ts == FS_IDLE && tx_load && !tx_clr) |=> tx_busy;
	endproperty
	a_tx_take: assert property (p_tx_take) else $error("load not taken"); //RULE23
	property p_tx_start;
		@(posedge clk) disable iff (!rst_n)
			(st_ff.ts == FS_DATA && st_ff.tstart && bit_tick && !tx_clr) |=> !tx_line;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit"); //RULE25
	property p_zero_par;
		@(posedge clk) disable iff (!rst_n) (rx_done && parity_mode == PAR_ZERO) |-> !rx_par_err;
	endproperty
	a_zero_par: assert property (p_zero_par) else $error("zero parity judged"); //RULE6
	property p_seven_top;
		@(posedge clk) disable iff (!rst_n) (rx_done && !eight_bits) |-> !rx_byte[7];
	endproperty
	a_seven_top: assert property (p_seven_top) else $error("bit 7 set in 7-bit mode"); //RULE24
endmodule

// *** uart_ctl_top.sv ***
// Serial port control, error status and baud generation top
//
// How it works
// RULE1 - Power bit low gates clock and resets flags, shifter, buffer.
// RULE2 - Power bit low forces the receive input high.
// RULE3 - Transmit enable low synchronously resets the transmitter.
// RULE4 - Receive enable low synchronously resets the receiver.
// RULE5 - Parity field picks none, zero, odd or even parity.
// RULE6 - Zero parity mode never flags parity errors.
// RULE7 - Character length bit picks seven or eight data bits.
// RULE8 - Stop length bit picks one or two transmitted stop bits.
// RULE9 - Receiver checks only the first stop bit.
// RULE10 - Software always writes one to mode bit zero.
// RULE11 - Power on before enables; enables off before power off.
// RULE12 - Enabling reception with line low starts a reception.
// RULE13 - Enables synchronised to base clock; wait two base clocks. Code steps on core cycles while the generator is stopped.
// RULE14 - Software disables before changing format or divisor.
// RULE15 - Error register clears on reset, power off or receive off.
// RULE16 - Reading the error register clears all its flags.
// RULE17 - Parity error set when received parity disagrees.
// RULE18 - Framing error set when first stop bit is low.
// RULE19 - Overrun set when buffer unread; new byte dropped.
// RULE20 - Clock select picks timer, divide by two, eight or 32.
// RULE21 - Divisor k from 8 to 31 divides base clock.
// RULE22 - Bit rate is divider output halved.
// RULE23 - Writing the transmit shifter starts transmission at once. Code sends the start bit on the next bit tick.
// RULE24 - Received bytes go to buffer; 7-bit data has top bit zero.
// RULE25 - Frame: start, LSB first data, optional parity, stops.
// RULE26 - Receive error event pulses when any flag is set.
`timescale 1ns/100ps
module uart_ctl_top
	import uart_ctl_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [15:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	input wire logic TIMER_TICK,
	input wire logic RX_LINE,
	output logic TX_LINE,
	output logic RX_ERR_EVT,
	output logic RX_DONE_EVT,
	output logic TX_DONE_EVT
);
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] baud;
		logic [7:0] errs;
		logic [7:0] rxbuf;
		logic unread;
		logic [1:0] tx_sync;
		logic [1:0] rx_sync;
		logic rx_m1;
		logic rx_m2;
		logic [7:0] rdata;
		logic err_evt;
		logic done_evt;
		logic txd_evt;
		logic tx_busy_d;
		logic tx_out;
	} top_state_t;
	top_state_t st_ff;
	top_state_t nxt_st;
	logic core_rst_n;
	logic rx_in;
	logic tx_clr;
	logic rx_clr;
	logic tx_line_w;
	logic tx_busy;
	logic rx_done;
	logic [7:0] rx_byte;
	logic rx_pe;
	logic rx_fe;
	logic tx_load;
	logic [7:0] err_set;
	baud_if bif ();

	// Power bit low holds the core in reset; mode and baud registers survive
	assign core_rst_n = RST_N & st_ff.mode[POWER_BIT]; //RULE1
	// Receive line sampled twice, then forced high while unpowered
	assign rx_in = st_ff.mode[POWER_BIT] ? st_ff.rx_m2 : 1'b1; //RULE2
	// Enables act after two sync steps: base clocks, or core cycles while the generator is stopped
	assign tx_clr = ~st_ff.tx_sync[1]; //RULE13
	assign rx_clr = ~st_ff.rx_sync[1]; //RULE13
	assign tx_load = WR && ADDR == ADDR_TXSR && st_ff.mode[TXEN_BIT] && !tx_clr;

	assign bif.clock_sel = st_ff.baud[CSEL_HI:CSEL_LO];
	assign bif.divisor = st_ff.baud[DIV_HI:DIV_LO];
	assign bif.run = st_ff.tx_sync[1] | st_ff.rx_sync[1];

	baud_gen u_baud (
		.clk(CORE_CLK),
		.rst_n(core_rst_n),
		.timer_tick(TIMER_TICK),
		.bif(bif)
	);

	uart_frame u_frame (
		.clk(CORE_CLK),
		.rst_n(core_rst_n),
		.tx_clr(tx_clr),
		.rx_clr(rx_clr),
		.base_tick(bif.base_tick),
		.bit_tick(bif.bit_tick),
		.parity_mode(st_ff.mode[PAR_HI:PAR_LO]),
		.eight_bits(st_ff.mode[CHAR_BIT]),
		.two_stops(st_ff.mode[STOP_BIT]),
		.tx_load(tx_load),
		.tx_byte(WDATA),
		.rx_line(rx_in),
		.tx_line(tx_line_w),
		.tx_busy(tx_busy),
		.rx_done(rx_done),
		.rx_byte(rx_byte),
		.rx_par_err(rx_pe),
		.rx_frm_err(rx_fe)
	);

	// Error bits raised by a finished reception
	always_comb begin
		err_set = '0;
		if (rx_done) begin
			err_set[PE_BIT] = rx_pe; //RULE17
			err_set[FE_BIT] = rx_fe; //RULE18
			err_set[OVE_BIT] = st_ff.unread; //RULE19
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.err_evt = 1'b0;
		nxt_st.done_evt = 1'b0;
		nxt_st.rx_m1 = RX_LINE;
		nxt_st.rx_m2 = st_ff.rx_m1;
		nxt_st.tx_busy_d = tx_busy;
		nxt_st.txd_evt = st_ff.tx_busy_d & ~tx_busy;
		// Pin retimed so it comes from a flop; idle high while unpowered
		nxt_st.tx_out = st_ff.mode[POWER_BIT] ? tx_line_w : 1'b1;
		// Enable sync advances on base clock ticks, or every cycle while the generator is not running
		if (!st_ff.mode[TXEN_BIT]) nxt_st.tx_sync = '0;
		else if (bif.base_tick || !bif.run) nxt_st.tx_sync = {st_ff.tx_sync[0], 1'b1};
		if (!st_ff.mode[RXEN_BIT]) nxt_st.rx_sync = '0;
		else if (bif.base_tick || !bif.run) nxt_st.rx_sync = {st_ff.rx_sync[0], 1'b1};
		// Register writes; bit 0 of mode is kept as written
		if (WR && ADDR == ADDR_MODE) nxt_st.mode = WDATA;
		if (WR && ADDR == ADDR_BAUD) nxt_st.baud = WDATA;
		// Reads; error read clears flags, but a same-cycle set wins
		nxt_st.rdata = '0;
		if (RD) begin
			case (ADDR)
				ADDR_MODE: nxt_st.rdata = st_ff.mode;
				ADDR_BAUD: nxt_st.rdata = st_ff.baud;
				ADDR_ERRS: nxt_st.rdata = st_ff.errs;
				ADDR_RXBF: nxt_st.rdata = st_ff.rxbuf;
				default: nxt_st.rdata = '0;
			endcase
		end
		if (RD && ADDR == ADDR_ERRS) nxt_st.errs = ERRS_RESET; //RULE16
		if (RD && ADDR == ADDR_RXBF) nxt_st.unread = 1'b0;
		nxt_st.errs = nxt_st.errs | err_set;
		if (rx_done) begin
			nxt_st.done_evt = 1'b1;
			nxt_st.err_evt = |err_set; //RULE26
			if (!st_ff.unread) begin //RULE19
				nxt_st.rxbuf = rx_byte; //RULE24
				nxt_st.unread = 1'b1;
			end
		end
		// Power or receive off clears errors and the unread mark
		if (!st_ff.mode[POWER_BIT] || !st_ff.mode[RXEN_BIT]) begin //RULE15
			nxt_st.errs = ERRS_RESET;
			nxt_st.unread = 1'b0;
		end
		if (!st_ff.mode[POWER_BIT]) nxt_st.rxbuf = BYTE_ONES; //RULE1
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_ff <= '0;
			st_ff.mode <= MODE_RESET;
			st_ff.baud <= BAUD_RESET;
			st_ff.rxbuf <= BYTE_ONES;
			st_ff.rx_m1 <= 1'b1;
			st_ff.rx_m2 <= 1'b1;
			st_ff.tx_out <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign TX_LINE = st_ff.tx_out;
	assign RDATA = st_ff.rdata;
	assign RX_ERR_EVT = st_ff.err_evt;
	assign RX_DONE_EVT = st_ff.done_evt;
	assign TX_DONE_EVT = st_ff.txd_evt;

	property p_err_clear_off;
		@(posedge CORE_CLK) disable iff (!RST_N)
			!st_ff.mode[RXEN_BIT] |=> st_ff.errs == ERRS_RESET;
	endproperty
	a_err_clear_off: assert property (p_err_clear_off) else $error("errors kept"); //RULE15
	property p_read_clear;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(RD && ADDR == ADDR_ERRS && !rx_done) |=> st_ff.errs == ERRS_RESET;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear"); //RULE16
	property p_overrun_keep;
		@(posedge CORE_CLK) disable iff (!RST_N)
			(rx_done && st_ff.unread && st_ff.mode[RXEN_BIT] && st_ff.mode[POWER_BIT])
			|=> st_ff.errs[OVE_BIT] && st_ff.rxbuf == $past(st_ff.rxbuf);
	endproperty
	a_overrun_keep: assert property (p_overrun_keep) else $error("overrun mishandled"); //RULE19
	property p_power_off;
		@(posedge CORE_CLK) disable iff (!RST_N)
			!st_ff.mode[POWER_BIT] |=> ##1 TX_LINE && st_ff.rxbuf == BYTE_ONES;
	endproperty
	a_power_off: assert property (p_power_off) else $error("power off not reset"); //RULE1
	property p_err_evt;
		@(posedge CORE_CLK) disable iff (!RST_N) (rx_done && (rx_pe || rx_fe)) |=> RX_ERR_EVT;
	endproperty
	a_err_evt: assert property (p_err_evt) else $error("missing error event"); //RULE26
endmodule

// *** uart_peer.sv ***
// Remote serial peer: sends frames to the receive pin, captures frames from the transmit pin
`timescale 1ns/100ps
module uart_peer (
	input wire logic clk,
	input wire logic tx_line,
	output logic rx_line
);
	int bit_cyc = 32;

	// Idle mark level, so enabling reception never sees a false start
	initial rx_line = 1'b1;

	// Start, data LSB first, parity, stops, all given in bit order
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rx_line = bits[i];
			repeat (bit_cyc) @(posedge clk);
			#1;
		end
		rx_line = 1'b1;
	endtask

	// Samples mid-bit on the falling edge, clear of the launch edge
	task automatic grab(input int n, output logic [11:0] bits, output bit ok);
		ok = 1'b0;
		bits = '1;
		for (int i = 0; i < 4 * bit_cyc && !ok; i++) begin
			@(negedge clk);
			ok = (tx_line === 1'b0);
		end
		repeat (bit_cyc / 2) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = tx_line;
			repeat (bit_cyc) @(negedge clk);
		end
	endtask
endmodule

// *** test_uart_ctl_top.sv ***
// Self-checking bench for the serial port control, status and baud block
`timescale 1ns/100ps
module test_uart_ctl_top;
	import uart_ctl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic timer_tick = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic tx_line, rx_line, err_evt, done_evt, txd_evt;
	int bad_count = 0;
	int n_tests = 0;
	int n_err = 0;
	int n_done = 0;
	int n_txd = 0;

	uart_ctl_top dut_u (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR(wr), .RD(rd),
		.WDATA(wdata), .RDATA(rdata), .TIMER_TICK(timer_tick), .RX_LINE(rx_line),
		.TX_LINE(tx_line), .RX_ERR_EVT(err_evt), .RX_DONE_EVT(done_evt), .TX_DONE_EVT(txd_evt));
	uart_peer peer_u (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

	// 40 MHz core clock
	always #12.5 clk = ~clk;
	// Timer base clock: one-cycle pulse every other cycle, used by the first tx case
	always @(posedge clk) begin
		#1 timer_tick = ~timer_tick;
	end
	// Event pulses counted on the falling edge, away from their launch
	always @(negedge clk) begin
		if (err_evt === 1'b1) n_err++;
		if (done_evt === 1'b1) n_done++;
		if (txd_evt === 1'b1) n_txd++;
	end

	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One-cycle strobes with an idle cycle after, so no strobe is set twice in a step
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask

	task automatic chk_reg(input string what, input logic [15:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		cmp(what, {8'h00, e}, {8'h00, rdata});
		tick(1);
	endtask

	function automatic logic [7:0] mode(input logic [1:0] par, input logic cl, input logic sl,
		input logic tx, input logic rx);
		return {1'b1, tx, rx, par, cl, sl, 1'b1};
	endfunction

	// Expected line image; flip spoils parity, brk pulls the first stop low
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [1:0] par,
		input logic cl, input logic sl, input logic flip, input logic brk, output int n);
		logic [11:0] f;
		logic x;
		int nd;
		nd = cl ? 8 : 7;
		f = '1;
		f[0] = 1'b0;
		x = 1'b0;
		for (int i = 0; i < nd; i++) begin
			f[1 + i] = d[i];
			x = x ^ d[i];
		end
		n = 1 + nd;
		if (par != PAR_NONE) begin
			f[n] = ((par == PAR_ODD) ? ~x : (par == PAR_EVEN) ? x : 1'b0) ^ flip;
			n++;
		end
		f[n] = ~brk;
		n = n + 1 + int'(sl);
		return f;
	endfunction

	// Format and divisor only change with both directions off, two base ticks apart
	task automatic setup(input logic [7:0] b, input logic [7:0] m);
		int base_cyc;
		// Base clock period in core cycles; the bench timer pulses every second cycle
		base_cyc = (b[6:5] == 2'h2) ? 8 : (b[6:5] == 2'h3) ? 32 : 2;
		wr_reg(ADDR_MODE, 8'h81);
		tick(70);
		wr_reg(ADDR_BAUD, b);
		wr_reg(ADDR_MODE, m);
		tick(40);
		peer_u.bit_cyc = 2 * int'(b[4:0]) * base_cyc;
	endtask

	task automatic t_regs();
		chk_reg("mode reset", ADDR_MODE, MODE_RESET);
		chk_reg("baud reset", ADDR_BAUD, BAUD_RESET);
		chk_reg("flags reset", ADDR_ERRS, ERRS_RESET);
		chk_reg("buffer reset", ADDR_RXBF, BYTE_ONES);
		wr_reg(16'hff75, 8'h5a);
		chk_reg("unmapped", 16'hff75, 8'h00);
		wr_reg(ADDR_ERRS, 8'hff);
		chk_reg("flags read only", ADDR_ERRS, 8'h00);
		wr_reg(ADDR_BAUD, 8'h28);
		chk_reg("baud write", ADDR_BAUD, 8'h28);
		$display("test regs done");
	endtask

	task automatic t_tx();
		logic [7:0] bv [4] = '{8'h08, 8'h28, 8'h68, 8'h5f};
		logic [1:0] pv [4] = '{PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN};
		logic [7:0] dv [4] = '{8'h87, 8'h55, 8'hb6, 8'h55};
		logic [11:0] exp;
		logic [11:0] got;
		int n;
		int t0;
		bit ok;
		for (int i = 0; i < 4; i++) begin
			setup(bv[i], mode(pv[i], i != 2, i[0], 1'b1, 1'b0));
			exp = frame(dv[i], pv[i], i != 2, i[0], 1'b0, 1'b0, n);
			t0 = n_txd;
			wr_reg(ADDR_TXSR, dv[i]);
			peer_u.grab(n, got, ok);
			cmp("tx start seen", 16'h0001, {15'h0, ok});
			cmp("tx frame", {4'h0, exp}, {4'h0, got});
			tick(peer_u.bit_cyc);
			cmp("tx done events", 16'h0001, 16'(n_txd - t0));
		end
		$display("test tx done");
	endtask

	task automatic rx_case(input logic [1:0] par, input logic cl, input logic [7:0] d,
		input logic flip, input logic brk, input logic [7:0] eb, input logic [7:0] ee);
		logic [11:0] f;
		int n;
		int e0;
		int d0;
		setup(8'h28, mode(par, cl, 1'b0, 1'b0, 1'b1));
		f = frame(d, par, cl, 1'b0, flip, brk, n);
		e0 = n_err;
		d0 = n_done;
		peer_u.send(f, n);
		tick(64);
		cmp("rx done events", 16'h0001, 16'(n_done - d0));
		cmp("rx error events", {15'h0, ee != 8'h00}, 16'(n_err - e0));
		chk_reg("rx buffer", ADDR_RXBF, eb);
		chk_reg("error flags", ADDR_ERRS, ee);
		chk_reg("flags after read", ADDR_ERRS, 8'h00);
	endtask

	task automatic t_rx();
		rx_case(PAR_EVEN, 1'b1, 8'ha5, 1'b0, 1'b0, 8'ha5, 8'h00);
		rx_case(PAR_ODD, 1'b0, 8'h36, 1'b0, 1'b0, 8'h36, 8'h00);
		rx_case(PAR_EVEN, 1'b1, 8'h3c, 1'b1, 1'b0, 8'h3c, 8'h04);
		rx_case(PAR_ZERO, 1'b1, 8'h81, 1'b1, 1'b0, 8'h81, 8'h00);
		rx_case(PAR_NONE, 1'b1, 8'h5a, 1'b0, 1'b1, 8'h5a, 8'h02);
		$display("test rx done");
	endtask

	// Two frames back to back with one stop each, receiver set for two stops
	task automatic t_ovr();
		logic [11:0] f1;
		logic [11:0] f2;
		int n;
		setup(8'h28, mode(PAR_NONE, 1'b1, 1'b1, 1'b0, 1'b1));
		f1 = frame(8'h11, PAR_NONE, 1'b1, 1'b0, 1'b0, 1'b0, n);
		f2 = frame(8'h22, PAR_NONE, 1'b1, 1'b0, 1'b0, 1'b0, n);
		peer_u.send(f1, n);
		// Line rests one cycle so it is never driven twice in one step
		tick(1);
		peer_u.send(f2, n);
		tick(64);
		chk_reg("overrun flag", ADDR_ERRS, 8'h01);
		chk_reg("buffer kept", ADDR_RXBF, 8'h11);
		$display("test overrun done");
	endtask

	task automatic t_off();
		logic [11:0] f;
		int n;
		setup(8'h28, mode(PAR_NONE, 1'b1, 1'b0, 1'b1, 1'b0));
		wr_reg(ADDR_TXSR, 8'h00);
		tick(48);
		cmp("line mid frame", 16'h0000, {15'h0, tx_line});
		wr_reg(ADDR_MODE, 8'h81);
		tick(4);
		cmp("line after tx off", 16'h0001, {15'h0, tx_line});
		wr_reg(ADDR_TXSR, 8'h00);
		tick(40);
		cmp("write while tx off", 16'h0001, {15'h0, tx_line});
		setup(8'h28, mode(PAR_NONE, 1'b1, 1'b0, 1'b0, 1'b1));
		f = frame(8'h5a, PAR_NONE, 1'b1, 1'b0, 1'b0, 1'b1, n);
		peer_u.send(f, n);
		tick(64);
		wr_reg(ADDR_MODE, 8'h81);
		chk_reg("flags rx off", ADDR_ERRS, 8'h00);
		wr_reg(ADDR_MODE, 8'h01);
		tick(4);
		chk_reg("buffer power off", ADDR_RXBF, 8'hff);
		chk_reg("flags power off", ADDR_ERRS, 8'h00);
		$display("test power done");
	endtask

	// Watchdog sized well above the roughly 19000 cycles the tests take
	initial begin
		#(60000 * 25);
		bad_count++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_ovr();
		t_off();
		close_out();
	end
endmodule
